// [logic/aerhl_pkg.sv]
// constants shared by the correctable-mask and header-log register bank
`default_nettype none
package aerhl_pkg;
  // configuration byte offsets
  localparam logic [11:0] OFS_CORR_STATUS = 12'h110;
  localparam logic [11:0] OFS_CORR_MASK   = 12'h114;
  localparam logic [11:0] OFS_CAP_CTRL    = 12'h118;
  localparam logic [11:0] OFS_HDR_DW0     = 12'h11C;
  localparam logic [11:0] OFS_HDR_DW1     = 12'h120;
  localparam logic [11:0] OFS_HDR_DW2     = 12'h124;
  localparam logic [11:0] OFS_HDR_DW3     = 12'h128;
  // correctable error bit positions, index 0..4
  localparam int          POS_RX_ERROR     = 0;
  localparam int          POS_BAD_TLP      = 6;
  localparam int          POS_BAD_DLLP     = 7;
  localparam int          POS_REPLAY_ROLL  = 8;
  localparam int          POS_REPLAY_EXPIRY = 12;
  localparam int          NUM_CORR         = 5;
  localparam logic [4:0][4:0] CORR_POS     = {5'd12, 5'd8, 5'd7, 5'd6, 5'd0};
  localparam logic [31:0] CORR_RW_BITS     = 32'h0000_11C1;
  // capability / control field positions
  localparam int          POS_CHK_EN       = 8;
  localparam int          POS_CHK_CAPABLE  = 7;
  localparam int          POS_GEN_EN       = 6;
  localparam int          POS_GEN_CAPABLE  = 5;
  localparam int          PTR_W            = 5;
  localparam logic [31:0] CTRL_RW_BITS     = 32'h0000_0140;
  localparam logic [31:0] CAP_CONST_BITS   = 32'h0000_00A0;
  // reset values
  localparam logic [31:0] RST_CORR_MASK    = 32'h0000_0000;
  localparam logic [31:0] RST_CORR_STATUS  = 32'h0000_0000;
  localparam logic [31:0] RST_HDR          = 32'h0000_0000;
  localparam logic [4:0]  RST_PTR          = 5'h00;
  localparam int          HDR_WORDS        = 4;
  // configuration access sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOK = 3'b010,
    ST_DONE = 3'b100
  } aerhl_state_t;
endpackage : aerhl_pkg
`default_nettype wire

// [logic/aerhl_sync.sv]
// two-flop synchroniser for an asynchronous reset request pin
`timescale 1ns/1ps
`default_nettype none
module aerhl_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      level_out
);
  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  always_comb
  begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign level_out = sync_ff;
endmodule : aerhl_sync
`default_nettype wire

// [logic/aerhl_hdr_store.sv]
// four-doubleword header store, written as a whole, read one word at a time
`timescale 1ns/1ps
`default_nettype none
module aerhl_hdr_store (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // capture side
  input  wire logic          clr,
  input  wire logic          wr_en,
  input  wire logic [127:0]  wr_data,
  // read side, data registered
  input  wire logic [1:0]    rd_idx,
  output logic      [31:0]   rd_data
);
  logic [3:0][31:0] mem_ff;
  logic [3:0][31:0] nxt_mem;
  logic [31:0]      rd_ff;
  logic [31:0]      nxt_rd;

  always_comb
  begin
    nxt_mem = mem_ff;
    if (clr)
      nxt_mem = {aerhl_pkg::HDR_WORDS{aerhl_pkg::RST_HDR}};
    else if (wr_en)
      nxt_mem = wr_data;
    nxt_rd = mem_ff[rd_idx];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_ff <= {aerhl_pkg::HDR_WORDS{aerhl_pkg::RST_HDR}};
      rd_ff  <= aerhl_pkg::RST_HDR;
    end
    else
    begin
      mem_ff <= nxt_mem;
      rd_ff  <= nxt_rd;
    end
  end

  assign rd_data = rd_ff;
endmodule : aerhl_hdr_store
`default_nettype wire

// [logic/aerhl_bank.sv]
// correctable error mask, capability/control and header log register bank
`timescale 1ns/1ps
`default_nettype none
module aerhl_bank (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // asynchronous reset request pins
  input  wire logic          link_reset_in,
  input  wire logic          global_reset_in,
  // configuration request port
  input  wire logic          cfg_req,
  input  wire logic          cfg_wr,
  input  wire logic [11:0]   cfg_addr,
  input  wire logic [3:0]    cfg_be,
  input  wire logic [31:0]   cfg_wdata,
  output logic               cfg_ack,
  output logic               cfg_hit,
  output logic      [31:0]   cfg_rdata,
  // error detectors, same clock, one-cycle pulses
  input  wire logic [4:0]    corr_err_in,
  input  wire logic          uncor_err_valid,
  input  wire logic          uncor_err_masked,
  input  wire logic [4:0]    uncor_err_bit,
  input  wire logic          first_err_rearm,
  input  wire logic          err_hdr_valid,
  input  wire logic [127:0]  err_hdr_wire,
  // outputs to link and transaction layers
  output logic               corr_msg_req,
  output logic               e2e_crc_check_enable,
  output logic               e2e_crc_gen_enable
);
  logic         link_rst_sync;
  logic         glob_rst_sync;
  logic         soft_clr;
  logic [31:0]  be_bits;
  logic [31:0]  evt32;
  logic [31:0]  hdr_rd;
  logic [127:0] hdr_ordered;
  logic         wr_take;
  logic         unmasked_evt;
  logic         hdr_load;

  aerhl_sync u_link_sync (
    .clock     (clock),
    .resetn    (resetn),
    .pin_in    (link_reset_in),
    .level_out (link_rst_sync)
  );

  aerhl_sync u_glob_sync (
    .clock     (clock),
    .resetn    (resetn),
    .pin_in    (global_reset_in),
    .level_out (glob_rst_sync)
  );

  // either synchronised reset request clears the registers and header log like power-on; the access sequencer is not reset
  assign soft_clr = link_rst_sync | glob_rst_sync;

  assign be_bits = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // place each detector pulse at its status bit position
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_evt
      always_comb
      begin
        evt32[gi] = 1'b0;
        for (int k = 0; k < aerhl_pkg::NUM_CORR; k++)
          if (int'(aerhl_pkg::CORR_POS[k]) == gi)
            evt32[gi] = corr_err_in[k];
      end
    end
    // wire order puts the first byte high; the log wants it low
    for (gi = 0; gi < 16; gi++)
    begin : g_swap
      assign hdr_ordered[(gi/4)*32 + (gi%4)*8 +: 8] = err_hdr_wire[(gi/4)*32 + (3-gi%4)*8 +: 8];
    end
  endgenerate

  // access sequencer
  aerhl_pkg::aerhl_state_t state_ff;
  aerhl_pkg::aerhl_state_t nxt_state;
  logic [11:0]             addr_ff;
  logic [11:0]             nxt_addr;
  logic                    rd_ff;
  logic                    nxt_rd;
  logic                    ack_ff;
  logic                    nxt_ack;
  logic                    hit_ff;
  logic                    nxt_hit;
  logic [31:0]             rdata_ff;
  logic [31:0]             nxt_rdata;

  // register state
  logic [31:0] mask_ff;
  logic [31:0] nxt_mask;
  logic [31:0] stat_ff;
  logic [31:0] nxt_stat;
  logic        chk_en_ff;
  logic        nxt_chk_en;
  logic        gen_en_ff;
  logic        nxt_gen_en;
  logic [4:0]  ptr_ff;
  logic [4:0]  nxt_ptr;
  logic        ptr_lock_ff;
  logic        nxt_ptr_lock;
  logic        msg_ff;
  logic        nxt_msg;

  // requests arriving while busy are dropped, so one access at a time
  assign wr_take = (state_ff == aerhl_pkg::ST_IDLE) && cfg_req && cfg_wr;

  assign unmasked_evt = (|(evt32 & ~mask_ff)) || (uncor_err_valid && !uncor_err_masked);
  assign hdr_load     = err_hdr_valid && unmasked_evt && !soft_clr;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_rd    = rd_ff;
    nxt_ack   = 1'b0;
    nxt_hit   = hit_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      aerhl_pkg::ST_IDLE:
      begin
        if (cfg_req)
        begin
          nxt_state = aerhl_pkg::ST_LOOK;
          nxt_addr  = cfg_addr;
          nxt_rd    = !cfg_wr;
        end
      end
      aerhl_pkg::ST_LOOK:
      begin
        nxt_state = aerhl_pkg::ST_DONE;
        nxt_ack   = 1'b1;
        nxt_hit   = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (addr_ff)
          aerhl_pkg::OFS_CORR_STATUS: nxt_rdata = stat_ff;
          aerhl_pkg::OFS_CORR_MASK:   nxt_rdata = mask_ff & aerhl_pkg::CORR_RW_BITS;
          aerhl_pkg::OFS_CAP_CTRL:
          begin
            nxt_rdata = aerhl_pkg::CAP_CONST_BITS;
            nxt_rdata[aerhl_pkg::POS_CHK_EN] = chk_en_ff;
            nxt_rdata[aerhl_pkg::POS_GEN_EN] = gen_en_ff;
            nxt_rdata[aerhl_pkg::PTR_W-1:0]  = ptr_ff;
          end
          aerhl_pkg::OFS_HDR_DW0,
          aerhl_pkg::OFS_HDR_DW1,
          aerhl_pkg::OFS_HDR_DW2,
          aerhl_pkg::OFS_HDR_DW3:     nxt_rdata = hdr_rd;
          default:                    nxt_hit = 1'b0;
        endcase
        if (!rd_ff)
          nxt_rdata = 32'h0000_0000;
      end
      aerhl_pkg::ST_DONE:
        nxt_state = aerhl_pkg::ST_IDLE;
      default:
        nxt_state = aerhl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= aerhl_pkg::ST_IDLE;
      addr_ff  <= 12'h000;
      rd_ff    <= 1'b0;
      ack_ff   <= 1'b0;
      hit_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      rd_ff    <= nxt_rd;
      ack_ff   <= nxt_ack;
      hit_ff   <= nxt_hit;
      rdata_ff <= nxt_rdata;
    end
  end

  // register updates; only writable positions ever take write data
  always_comb
  begin
    nxt_mask     = mask_ff;
    nxt_stat     = (stat_ff | (evt32 & ~mask_ff)) & aerhl_pkg::CORR_RW_BITS;
    nxt_chk_en   = chk_en_ff;
    nxt_gen_en   = gen_en_ff;
    nxt_ptr      = ptr_ff;
    nxt_ptr_lock = ptr_lock_ff && !first_err_rearm;
    nxt_msg      = |(evt32 & ~mask_ff);
    if (wr_take && cfg_addr == aerhl_pkg::OFS_CORR_MASK)
      nxt_mask = (mask_ff & ~(be_bits & aerhl_pkg::CORR_RW_BITS))
               | (cfg_wdata & be_bits & aerhl_pkg::CORR_RW_BITS);
    // write-one clear loses against a fresh event in the same cycle
    if (wr_take && cfg_addr == aerhl_pkg::OFS_CORR_STATUS)
      nxt_stat = (stat_ff & ~(cfg_wdata & be_bits)) | (evt32 & ~mask_ff);
    if (wr_take && cfg_addr == aerhl_pkg::OFS_CAP_CTRL && cfg_be[1])
      nxt_chk_en = cfg_wdata[aerhl_pkg::POS_CHK_EN];
    if (wr_take && cfg_addr == aerhl_pkg::OFS_CAP_CTRL && cfg_be[0])
      nxt_gen_en = cfg_wdata[aerhl_pkg::POS_GEN_EN];
    // pointer names an uncorrectable status bit and only the first one sticks until first_err_rearm or a reset request frees it
    if (uncor_err_valid && !uncor_err_masked && (!ptr_lock_ff || first_err_rearm))
    begin
      nxt_ptr      = uncor_err_bit;
      nxt_ptr_lock = 1'b1;
    end
    if (soft_clr)
    begin
      nxt_mask     = aerhl_pkg::RST_CORR_MASK;
      nxt_stat     = aerhl_pkg::RST_CORR_STATUS;
      nxt_chk_en   = 1'b0;
      nxt_gen_en   = 1'b0;
      nxt_ptr      = aerhl_pkg::RST_PTR;
      nxt_ptr_lock = 1'b0;
      nxt_msg      = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mask_ff     <= aerhl_pkg::RST_CORR_MASK;
      stat_ff     <= aerhl_pkg::RST_CORR_STATUS;
      chk_en_ff   <= 1'b0;
      gen_en_ff   <= 1'b0;
      ptr_ff      <= aerhl_pkg::RST_PTR;
      ptr_lock_ff <= 1'b0;
      msg_ff      <= 1'b0;
    end
    else
    begin
      mask_ff     <= nxt_mask;
      stat_ff     <= nxt_stat;
      chk_en_ff   <= nxt_chk_en;
      gen_en_ff   <= nxt_gen_en;
      ptr_ff      <= nxt_ptr;
      ptr_lock_ff <= nxt_ptr_lock;
      msg_ff      <= nxt_msg;
    end
  end

  // header log has no write path from configuration at all
  aerhl_hdr_store u_hdr (
    .clock   (clock),
    .resetn  (resetn),
    .clr     (soft_clr),
    .wr_en   (hdr_load),
    .wr_data (hdr_ordered),
    .rd_idx  (2'((cfg_addr - aerhl_pkg::OFS_HDR_DW0) >> 2)),
    .rd_data (hdr_rd)
  );

  assign cfg_ack              = ack_ff;
  assign cfg_hit              = hit_ff;
  assign cfg_rdata            = rdata_ff;
  assign corr_msg_req         = msg_ff;
  assign e2e_crc_check_enable = chk_en_ff;
  assign e2e_crc_gen_enable   = gen_en_ff;

  // checks
  default clocking aerhl_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  property p_mask_blocks;
    ((evt32 & mask_ff & ~stat_ff) != 0) |=> ((stat_ff & $past(evt32 & mask_ff & ~stat_ff)) == 0);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked error set status");
  property p_msg_cause;
    corr_msg_req |-> $past((evt32 & ~mask_ff) != 0);
  endproperty
  a_msg_cause: assert property (p_msg_cause) else $error("message without unmasked error");
  property p_masked_no_log;
    (err_hdr_valid && (evt32 & ~mask_ff) == 0 && !(uncor_err_valid && !uncor_err_masked)) |=> $stable(ptr_ff);
  endproperty
  a_masked_no_log: assert property (p_masked_no_log) else $error("masked error moved pointer");
  property p_reserved_zero;
    (mask_ff & ~aerhl_pkg::CORR_RW_BITS) == 0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mask bit stored");
  property p_chk_write;
    (wr_take && cfg_addr == aerhl_pkg::OFS_CAP_CTRL && cfg_be[1] && !soft_clr)
      |=> e2e_crc_check_enable == $past(cfg_wdata[aerhl_pkg::POS_CHK_EN]);
  endproperty
  a_chk_write: assert property (p_chk_write) else $error("check enable not written");
  property p_cap_read;
    (state_ff == aerhl_pkg::ST_LOOK && rd_ff && addr_ff == aerhl_pkg::OFS_CAP_CTRL)
      |=> cfg_ack && cfg_rdata[aerhl_pkg::POS_CHK_CAPABLE] && cfg_rdata[aerhl_pkg::POS_GEN_CAPABLE];
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability bits not one");
  property p_ack_latency;
    (state_ff == aerhl_pkg::ST_IDLE && cfg_req) |=> !cfg_ack ##1 cfg_ack ##1 !cfg_ack;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("answer not two cycles after request");
  property p_set_wins;
    (corr_err_in[0] && !mask_ff[0] && !soft_clr) |=> stat_ff[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");
  property p_soft_clr;
    soft_clr |=> (mask_ff == 0 && ptr_ff == 0 && !e2e_crc_gen_enable);
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("reset request left state");

  c_mask_write:  cover property (wr_take && cfg_addr == aerhl_pkg::OFS_CORR_MASK);
  c_hdr_capture: cover property (hdr_load);
  c_collision:   cover property (wr_take && cfg_addr == aerhl_pkg::OFS_CORR_STATUS && (evt32 & ~mask_ff) != 0);
  c_hdr_read:    cover property (cfg_ack && addr_ff == aerhl_pkg::OFS_HDR_DW3);
  c_rearm_load:  cover property (uncor_err_valid && !uncor_err_masked && ptr_lock_ff && first_err_rearm);
endmodule : aerhl_bank
`default_nettype wire

// [bench/aerhl_host.sv]
// root-complex model issuing single-word configuration requests
`timescale 1ns/1ps
`default_nettype none
module aerhl_host (
  // clock
  input  wire logic        clock,
  // request side
  output logic             cfg_req,
  output logic             cfg_wr,
  output logic [11:0]      cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // answer side
  input  wire logic        cfg_ack,
  input  wire logic        cfg_hit,
  input  wire logic [31:0] cfg_rdata
);
  logic [31:0] rd_q;
  logic        hit_q;
  logic        ok_q;
  initial
  begin
    cfg_req   = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 12'h000;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // request held until the answer edge; qualifiers inverted after it so stale values never look valid
  task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    int n;
    begin
      @(negedge clock);
      cfg_req   = 1'b1;
      cfg_wr    = wr;
      cfg_addr  = a;
      cfg_be    = be;
      cfg_wdata = d;
      ok_q      = 1'b0;
      // answer read while it stands ahead of the edge that samples it
      for (n = 0; n < 8 && !ok_q; n++)
      begin
        @(negedge clock);
        ok_q  = (cfg_ack === 1'b1);
        rd_q  = cfg_rdata;
        hit_q = cfg_hit;
      end
      // released only after that edge, once the sequencer is idle again but before it samples the next request
      @(negedge clock);
      cfg_req   = 1'b0;
      cfg_wr    = ~wr;
      cfg_addr  = ~a;
      cfg_be    = ~be;
      cfg_wdata = ~d;
    end
  endtask : access
endmodule : aerhl_host
`default_nettype wire

// [bench/aer_correctable_mask_and_header_log_test.sv]
// self-checking bench for the correctable-mask and header-log bank
`timescale 1ns/1ps
`default_nettype none
module aer_correctable_mask_and_header_log_test;
  logic         clock;
  logic         resetn;
  logic         link_reset_in;
  logic         global_reset_in;
  logic         cfg_req;
  logic         cfg_wr;
  logic [11:0]  cfg_addr;
  logic [3:0]   cfg_be;
  logic [31:0]  cfg_wdata;
  logic         cfg_ack;
  logic         cfg_hit;
  logic [31:0]  cfg_rdata;
  logic [4:0]   corr_err_in;
  logic         uncor_err_valid;
  logic         uncor_err_masked;
  logic [4:0]   uncor_err_bit;
  logic         first_err_rearm;
  logic         err_hdr_valid;
  logic [127:0] err_hdr_wire;
  logic         corr_msg_req;
  logic         e2e_crc_check_enable;
  logic         e2e_crc_gen_enable;
  int           errors;
  int           samples_checked;
  logic [31:0]  m_stat;
  logic [31:0]  m_mask;
  logic [31:0]  m_en;
  logic [4:0]   m_ptr;
  logic         m_lock;
  logic [127:0] m_hdr;
  logic [31:0]  d;

  aerhl_bank uut (
    .clock(clock), .resetn(resetn), .link_reset_in(link_reset_in), .global_reset_in(global_reset_in),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata), .corr_err_in(corr_err_in),
    .uncor_err_valid(uncor_err_valid), .uncor_err_masked(uncor_err_masked), .uncor_err_bit(uncor_err_bit),
    .first_err_rearm(first_err_rearm), .err_hdr_valid(err_hdr_valid), .err_hdr_wire(err_hdr_wire),
    .corr_msg_req(corr_msg_req), .e2e_crc_check_enable(e2e_crc_check_enable),
    .e2e_crc_gen_enable(e2e_crc_gen_enable)
  );
  aerhl_host host (
    .clock(clock), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata)
  );

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32
  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check1
  function automatic logic [31:0] bsw(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : bsw
  function automatic logic [4:0] live(input logic [4:0] ce, input logic [31:0] mk);
    logic [4:0] r;
    for (int i = 0; i < 5; i++)
      r[i] = ce[i] & ~mk[aerhl_pkg::CORR_POS[i]];
    return r;
  endfunction : live
  task automatic zero_model;
    {m_stat, m_mask, m_en, m_ptr, m_lock, m_hdr} = '0;
  endtask : zero_model
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic hit);
    host.access(1'b0, a, 4'hF, 32'h0000_0000);
    check1(host.ok_q, 1'b1);
    check1(host.hit_q, hit);
    check32(host.rd_q, exp);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] w);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & w;
    host.access(1'b1, a, be, w);
    check1(host.ok_q, 1'b1);
    check32(host.rd_q, 32'h0000_0000);
    if (a == aerhl_pkg::OFS_CORR_MASK)
      m_mask = (m_mask & ~({{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h0000_11C1)) | (bm & 32'h0000_11C1);
    if (a == aerhl_pkg::OFS_CAP_CTRL)
      m_en = (m_en & ~({{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'h0000_0140)) | (bm & 32'h0000_0140);
    if (a == aerhl_pkg::OFS_CORR_STATUS)
      m_stat = m_stat & ~bm;
  endtask : wr
  task automatic rdall;
    rd(aerhl_pkg::OFS_CORR_STATUS, m_stat, 1'b1);
    rd(aerhl_pkg::OFS_CORR_MASK, m_mask, 1'b1);
    rd(aerhl_pkg::OFS_CAP_CTRL, m_en | 32'h0000_00A0 | 32'(m_ptr), 1'b1);
    for (int i = 0; i < 4; i++)
      rd(12'h11C + 12'(4 * i), bsw(m_hdr[32 * i +: 32]), 1'b1);
    check1(e2e_crc_check_enable, m_en[8]);
    check1(e2e_crc_gen_enable, m_en[6]);
  endtask : rdall
  // r carries the uncorrectable event fields: valid, masked, bit position
  task automatic fire(input logic [4:0] ce, input logic [31:0] r, input logic rearm);
    logic [127:0] h;
    logic [4:0]   hit;
    h   = {$urandom, $urandom, $urandom, $urandom};
    hit = live(ce, m_mask);
    @(negedge clock);
    {corr_err_in, err_hdr_valid, err_hdr_wire} = {ce, 1'b1, h};
    {uncor_err_valid, uncor_err_masked, uncor_err_bit, first_err_rearm} = {r[0], r[1], r[6:2], rearm};
    if (|hit || (r[0] && !r[1]))
      m_hdr = h;
    if (rearm)
      m_lock = 1'b0;
    if (r[0] && !r[1] && !m_lock)
      {m_ptr, m_lock} = {r[6:2], 1'b1};
    for (int i = 0; i < 5; i++)
      m_stat[aerhl_pkg::CORR_POS[i]] |= hit[i];
    @(negedge clock);
    {corr_err_in, err_hdr_valid, err_hdr_wire, uncor_err_valid, first_err_rearm} = {6'h00, ~h, 2'b00};
    check1(corr_msg_req, |hit);
    @(negedge clock);
    check1(corr_msg_req, 1'b0);
  endtask : fire
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clock = 1'b0;
    forever
      #5 clock = ~clock;
  end
  // run needs roughly 15 us; a hang is cut well past that
  initial
  begin
    #200us;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {resetn, link_reset_in, global_reset_in, corr_err_in, err_hdr_valid, err_hdr_wire} = '0;
    {uncor_err_valid, uncor_err_masked, uncor_err_bit, first_err_rearm} = '0;
    {errors, samples_checked} = '0;
    zero_model();
    void'($urandom(30));
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    rdall();
    rd(12'h200, 32'h0000_0000, 1'b0);
    $display("test reset_values done");
    for (int k = 0; k < 10; k++)
    begin
      d = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0000_0000 : $urandom;
      wr(aerhl_pkg::OFS_CORR_MASK, (k < 2) ? 4'hF : 4'($urandom), d);
      wr(aerhl_pkg::OFS_CAP_CTRL, (k < 2) ? 4'hF : 4'($urandom), d);
      wr(12'h11C + 12'(4 * (k % 4)), 4'hF, d);
      rdall();
    end
    $display("test register_access done");
    for (int k = 0; k < 24; k++)
    begin
      wr(aerhl_pkg::OFS_CORR_MASK, 4'hF, (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0000_0000 : $urandom);
      fire((k < 2) ? 5'h1F : 5'($urandom), $urandom, (k % 5) == 4);
      rdall();
      if (k % 4 == 3)
        wr(aerhl_pkg::OFS_CORR_STATUS, 4'hF, $urandom);
    end
    $display("test error_events done");
    for (int k = 0; k < 2; k++)
    begin
      wr(aerhl_pkg::OFS_CAP_CTRL, 4'hF, 32'hFFFF_FFFF);
      wr(aerhl_pkg::OFS_CORR_MASK, 4'hF, 32'h0000_0000);
      fire(5'h1F, 32'h0000_0035, 1'b1);
      @(negedge clock);
      {link_reset_in, global_reset_in} = (k == 0) ? 2'b10 : 2'b01;
      repeat (4) @(negedge clock);
      {link_reset_in, global_reset_in} = 2'b00;
      repeat (4) @(negedge clock);
      zero_model();
      rdall();
    end
    $display("test reset_pins done");
    tally_and_finish();
  end
endmodule : aer_correctable_mask_and_header_log_test
`default_nettype wire
